// ### logic/scm_top.sv
// System clock select, divider and low-power mode controller.
// Assumes oscillator outputs and ready pins are asynchronous to MCLK,
// and halt, wake and watchdog enable come from MCLK-domain logic.
//
// Contract
// - Divider field picks fH/1..fH/64 or fSUB
// - Bit 3 picks internal RC or crystal
// - Bit 2 picks low RC or 32k crystal
// - Bit 1 keeps high oscillator during halt
// - Bit 0 keeps low oscillator during halt
// - Low RC on: selected in run or kept idle, or watchdog
// - Watchdog keeps low RC despite keep off
// - Halt with both keeps off enters sleep
// - Sleep keeps low RC only for watchdog
// - Low-only idle: system clock only at 111
// - Dual idle: all clocks keep running
// - High-only idle: system clock except 111
// - Fast mode runs divided high clock
// - Slow mode runs selected low clock
// - Slow mode high clock follows enable bit
// - Bit 4 reads zero, not stored
// - RC frequency codes 8, 12, 16, 8 MHz
// - RC flag clears, sets, then frequency applies
// - Slow switch waits for stable low clock
//
// The register offsets and register access over APB were decided locally.
`include "scm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module scm_top
    import scm_pkg::*;
#(
    parameter int SETTLE_CYC = (`SCM_SETTLE_NS + `SCM_MCLK_NS - 1) / `SCM_MCLK_NS
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Oscillator pins: outputs and ready indications
    input wire logic INT_HI_RC_CLK,
    input wire logic EXT_HI_XTAL_CLK,
    input wire logic EXT_LO_XTAL_CLK,
    input wire logic INT_LO_RC_CLK,
    input wire logic INT_HI_READY,
    input wire logic EXT_HI_READY,
    input wire logic EXT_LO_READY,
    input wire logic INT_LO_READY,
    // Oscillator controls
    output logic INT_HI_OSC_EN,
    output logic EXT_HI_OSC_EN,
    output logic EXT_LO_OSC_EN,
    output logic INT_LO_OSC_EN,
    output logic [1:0] INT_HI_FREQ_SEL,
    output logic EXT_HI_FREQ_RANGE,
    // CPU and watchdog
    input wire logic HALT_REQ,
    input wire logic WAKE_REQ,
    input wire logic WATCHDOG_EN,
    output logic CPU_RUN,
    output logic [4:0] MODE,
    // Generated clocks
    output logic SYS_CLK,
    output logic HI_CLK,
    output logic LO_CLK,
    output logic INT_LO_RC_CLK_O
);

    localparam int NSYNC = 8;
    localparam int NOSC = 3;
    localparam logic [15:0] SETTLE = 16'(SETTLE_CYC);
    localparam logic [7:0] SCC_RST = `SCM_SYS_CLK_RST;

    // Two-stage synchronisers for all pin inputs
    logic [NSYNC-1:0] sync1_q, sync2_q;
    wire [NSYNC-1:0] pins = {INT_LO_READY, EXT_LO_READY, EXT_HI_READY, INT_HI_READY,
        INT_LO_RC_CLK, EXT_LO_XTAL_CLK, EXT_HI_XTAL_CLK, INT_HI_RC_CLK};
    always_ff @(posedge MCLK) begin
        if (RST) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end
    wire int_hi_rc_osc_s = sync2_q[0];
    wire hxt_s = sync2_q[1];
    wire lxt_s = sync2_q[2];
    wire int_lo_rc_osc_s = sync2_q[3];
    wire [NOSC-1:0] osc_rdy_s = sync2_q[6:4];
    wire int_lo_rc_osc_rdy_s = sync2_q[7];

    // Registers
    logic [2:0] div_sel_q;
    logic hi_src_sel_q, lo_src_sel_q, hi_osc_idle_keep_q, lo_osc_idle_keep_q;
    logic [1:0] int_hi_freq_sel_q, freq_applied_q;
    logic int_hi_osc_en_q, ext_hi_osc_en_q, ext_lo_osc_en_q, ext_hi_freq_range_q;
    logic [NOSC-1:0] flag_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    wire setup = PSEL & ~PENABLE;
    wire wr = PSEL & PENABLE & PWRITE;
    wire hit_scc = PADDR == `SCM_OFF_SYS_CLK;
    wire hit_int_hi_rc_osc = PADDR == `SCM_OFF_HI_RC;
    wire hit_hxt = PADDR == `SCM_OFF_HI_XTAL;
    wire hit_lxt = PADDR == `SCM_OFF_LO_XTAL;
    wire hit_any = hit_scc | hit_int_hi_rc_osc | hit_hxt | hit_lxt;
    wire [1:0] wr_freq = PWDATA[`SCM_FREQ_HI:`SCM_FREQ_LO];
    wire freq_change = wr & hit_int_hi_rc_osc & (wr_freq != int_hi_freq_sel_q);
    // Range is frozen while the crystal enable bit is set
    wire range_lock = ext_hi_osc_en_q;

    wire [7:0] scc_rd = {div_sel_q, 1'b0, hi_src_sel_q, lo_src_sel_q,
        hi_osc_idle_keep_q, lo_osc_idle_keep_q};
    wire [7:0] int_hi_rc_osc_rd = {4'h0, int_hi_freq_sel_q, flag_q[SCM_OSC_INT_HI], int_hi_osc_en_q};
    wire [7:0] hxt_rd = {5'h00, ext_hi_freq_range_q, flag_q[SCM_OSC_EXT_HI], ext_hi_osc_en_q};
    wire [7:0] lxt_rd = {6'h00, flag_q[SCM_OSC_EXT_LO], ext_lo_osc_en_q};
    wire [7:0] rd_mux = hit_scc ? scc_rd : hit_int_hi_rc_osc ? int_hi_rc_osc_rd : hit_hxt ? hxt_rd :
        hit_lxt ? lxt_rd : 8'h00;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_sel_q <= SCC_RST[`SCM_DIV_HI:`SCM_DIV_LO];
            hi_src_sel_q <= SCC_RST[`SCM_HI_SRC];
            lo_src_sel_q <= SCC_RST[`SCM_LO_SRC];
            hi_osc_idle_keep_q <= SCC_RST[`SCM_HI_KEEP];
            lo_osc_idle_keep_q <= SCC_RST[`SCM_LO_KEEP];
            int_hi_freq_sel_q <= `SCM_FREQ_8M;
            int_hi_osc_en_q <= `SCM_HI_RC_EN_RST;
            ext_hi_osc_en_q <= `SCM_OTHER_EN_RST;
            ext_lo_osc_en_q <= `SCM_OTHER_EN_RST;
            ext_hi_freq_range_q <= 1'b0;
        end else if (wr) begin
            if (hit_scc) begin
                div_sel_q <= PWDATA[`SCM_DIV_HI:`SCM_DIV_LO];
                hi_src_sel_q <= PWDATA[`SCM_HI_SRC];
                lo_src_sel_q <= PWDATA[`SCM_LO_SRC];
                hi_osc_idle_keep_q <= PWDATA[`SCM_HI_KEEP];
                lo_osc_idle_keep_q <= PWDATA[`SCM_LO_KEEP];
            end
            if (hit_int_hi_rc_osc) begin
                int_hi_freq_sel_q <= wr_freq;
                int_hi_osc_en_q <= PWDATA[`SCM_EN];
            end
            if (hit_hxt) begin
                ext_hi_osc_en_q <= PWDATA[`SCM_EN];
                if (!range_lock) begin
                    ext_hi_freq_range_q <= PWDATA[`SCM_RANGE];
                end
            end
            if (hit_lxt) begin
                ext_lo_osc_en_q <= PWDATA[`SCM_EN];
            end
        end
    end

    // Read data captured in setup, answered with no wait state
    always_ff @(posedge MCLK) begin
        if (RST) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= {24'h000000, rd_mux};
            pslverr_q <= ~hit_any;
        end
    end
    assign PRDATA = prdata_q;
    assign PSLVERR = pslverr_q & PSEL & PENABLE;
    assign PREADY = 1'b1;

    // Operating mode
    scm_mode_t mode_q, mode_d;
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            SCM_RUN: begin
                if (HALT_REQ) begin
                    case ({hi_osc_idle_keep_q, lo_osc_idle_keep_q})
                        2'b00: mode_d = SCM_SLEEP;
                        2'b01: mode_d = SCM_IDLE_LO;
                        2'b11: mode_d = SCM_IDLE_DUAL;
                        default: mode_d = SCM_IDLE_HI;
                    endcase
                end
            end
            SCM_SLEEP, SCM_IDLE_LO, SCM_IDLE_DUAL, SCM_IDLE_HI: begin
                if (WAKE_REQ) begin
                    mode_d = SCM_RUN;
                end
            end
            default: mode_d = SCM_RUN;
        endcase
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode_q <= SCM_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire run = mode_q == SCM_RUN;
    wire sel_sub = div_sel_q == `SCM_SEL_SUB;
    wire hi_allow = run | (mode_q == SCM_IDLE_DUAL) | (mode_q == SCM_IDLE_HI);
    wire lo_allow = run | (mode_q == SCM_IDLE_DUAL) | (mode_q == SCM_IDLE_LO);
    // Fast mode and high idles force the selected high source on
    wire hi_force = (run & ~sel_sub) | (hi_allow & ~run);
    wire lo_force = lo_allow;
    wire sys_want = run | (mode_q == SCM_IDLE_DUAL) |
        ((mode_q == SCM_IDLE_LO) & sel_sub) | ((mode_q == SCM_IDLE_HI) & ~sel_sub);

    // Oscillator enables; slow mode leaves high oscillators to their bits
    wire int_hi_on = hi_allow & (int_hi_osc_en_q | (~hi_src_sel_q & hi_force));
    wire ext_hi_on = hi_allow & (ext_hi_osc_en_q | (hi_src_sel_q & hi_force));
    wire ext_lo_on = lo_allow & (ext_lo_osc_en_q | (lo_src_sel_q & lo_force));
    wire int_lo_on = (lo_allow & ~lo_src_sel_q) | WATCHDOG_EN;
    assign INT_HI_OSC_EN = int_hi_on;
    assign EXT_HI_OSC_EN = ext_hi_on;
    assign EXT_LO_OSC_EN = ext_lo_on;
    assign INT_LO_OSC_EN = int_lo_on;
    assign EXT_HI_FREQ_RANGE = ext_hi_freq_range_q;
    assign CPU_RUN = run;
    assign MODE = mode_q;

    // Stability trackers: flag drops on enable or frequency change
    wire [NOSC-1:0] osc_on = {ext_lo_on, ext_hi_on, int_hi_on};
    wire [NOSC-1:0] restart = {2'b00, freq_change};
    logic [NOSC-1:0] on_q;
    logic [15:0] settle_q [NOSC];
    genvar gi;
    generate
        for (gi = 0; gi < NOSC; gi++) begin : g_osc
            wire start = ~osc_on[gi] | (osc_on[gi] & ~on_q[gi]) | restart[gi];
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    on_q[gi] <= 1'b0;
                    settle_q[gi] <= '0;
                    flag_q[gi] <= 1'b0;
                end else begin
                    on_q[gi] <= osc_on[gi];
                    if (start) begin
                        settle_q[gi] <= '0;
                        flag_q[gi] <= 1'b0;
                    end else if (osc_rdy_s[gi] && settle_q[gi] < SETTLE) begin
                        settle_q[gi] <= settle_q[gi] + 16'h0001;
                    end else if (osc_rdy_s[gi]) begin
                        flag_q[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // New RC frequency only takes effect once its flag is up
    always_ff @(posedge MCLK) begin
        if (RST) begin
            freq_applied_q <= `SCM_FREQ_8M;
        end else if (flag_q[SCM_OSC_INT_HI] && !freq_change) begin
            freq_applied_q <= int_hi_freq_sel_q;
        end
    end
    assign INT_HI_FREQ_SEL = (freq_applied_q == `SCM_FREQ_RSVD) ? `SCM_FREQ_8M :
        freq_applied_q;

    // High and low source selection
    wire fh_lvl = hi_src_sel_q ? hxt_s : int_hi_rc_osc_s;
    wire fh_ok = hi_src_sel_q ? flag_q[SCM_OSC_EXT_HI] : flag_q[SCM_OSC_INT_HI];
    wire fsub_lvl = lo_src_sel_q ? lxt_s : int_lo_rc_osc_s;
    wire fsub_ok = lo_src_sel_q ? flag_q[SCM_OSC_EXT_LO] : int_lo_rc_osc_rdy_s;

    // Sources in use now; they change only through the switch below
    logic cur_hs_q, cur_hs_d, cur_ls_q, cur_ls_d;
    wire fh_run = cur_hs_q ? hxt_s : int_hi_rc_osc_s;
    wire fsub_run = cur_ls_q ? lxt_s : int_lo_rc_osc_s;

    // Ripple divider advanced on each fH rising edge
    logic fh_d_q;
    logic [5:0] div_q;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            fh_d_q <= 1'b0;
            div_q <= '0;
        end else begin
            fh_d_q <= fh_run;
            if (fh_run & ~fh_d_q) begin
                div_q <= div_q + 6'h01;
            end
        end
    end
    wire [6:0] taps = {div_q, fh_run};

    // Glitch-free switch between selected sources
    scm_sw_t sw_q, sw_d;
    logic [2:0] cur_sel_q, cur_sel_d;
    logic sys_q, sys_d, gate_q, hi_clk_q, lo_clk_q, int_lo_rc_osc_clk_q;
    wire cur_lvl = (cur_sel_q == `SCM_SEL_SUB) ? fsub_run : taps[cur_sel_q];
    wire tgt_ok = sel_sub ? fsub_ok : fh_ok;
    wire sel_diff = (div_sel_q != cur_sel_q) | (hi_src_sel_q != cur_hs_q) |
        (lo_src_sel_q != cur_ls_q);

    always_comb begin
        sw_d = sw_q;
        cur_sel_d = cur_sel_q;
        cur_hs_d = cur_hs_q;
        cur_ls_d = cur_ls_q;
        sys_d = cur_lvl & gate_q;
        case (sw_q)
            SCM_SW_FOLLOW: begin
                if (sel_diff && tgt_ok) begin
                    sw_d = SCM_SW_DRAIN;
                end
            end
            SCM_SW_DRAIN: begin
                if (!cur_lvl) begin
                    cur_sel_d = div_sel_q;
                    cur_hs_d = hi_src_sel_q;
                    cur_ls_d = lo_src_sel_q;
                    sys_d = 1'b0;
                    sw_d = SCM_SW_ARM;
                end
            end
            SCM_SW_ARM: begin
                sys_d = 1'b0;
                if (!cur_lvl || sel_diff) begin
                    sw_d = SCM_SW_FOLLOW;
                end
            end
            default: begin
                sw_d = SCM_SW_FOLLOW;
                sys_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            sw_q <= SCM_SW_FOLLOW;
            cur_sel_q <= SCC_RST[`SCM_DIV_HI:`SCM_DIV_LO];
            cur_hs_q <= SCC_RST[`SCM_HI_SRC];
            cur_ls_q <= SCC_RST[`SCM_LO_SRC];
            sys_q <= 1'b0;
            gate_q <= 1'b1;
        end else begin
            sw_q <= sw_d;
            cur_sel_q <= cur_sel_d;
            cur_hs_q <= cur_hs_d;
            cur_ls_q <= cur_ls_d;
            sys_q <= sys_d;
            if (!cur_lvl) begin
                gate_q <= sys_want;
            end
        end
    end

    // Peripheral clocks
    always_ff @(posedge MCLK) begin
        if (RST) begin
            hi_clk_q <= 1'b0;
            lo_clk_q <= 1'b0;
            int_lo_rc_osc_clk_q <= 1'b0;
        end else begin
            hi_clk_q <= fh_lvl & fh_ok & hi_allow;
            lo_clk_q <= fsub_lvl & fsub_ok & lo_allow;
            int_lo_rc_osc_clk_q <= int_lo_rc_osc_s & int_lo_on;
        end
    end
    assign SYS_CLK = sys_q;
    assign HI_CLK = hi_clk_q;
    assign LO_CLK = lo_clk_q;
    assign INT_LO_RC_CLK_O = int_lo_rc_osc_clk_q;

endmodule

`default_nettype wire

// ### logic/scm_cfg.svh
// Register offsets, field positions, reset values and timing constants
// for the system clock and operating mode controller.
// Assumes a 32-bit APB slave with byte addresses on PADDR.
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

// Register byte addresses
`define SCM_OFF_SYS_CLK 8'h00
`define SCM_OFF_HI_RC 8'h04
`define SCM_OFF_HI_XTAL 8'h08
`define SCM_OFF_LO_XTAL 8'h0C

// System clock control fields
`define SCM_DIV_HI 7
`define SCM_DIV_LO 5
`define SCM_HI_SRC 3
`define SCM_LO_SRC 2
`define SCM_HI_KEEP 1
`define SCM_LO_KEEP 0
`define SCM_SYS_CLK_RST 8'h00

// Oscillator control fields
`define SCM_FREQ_HI 3
`define SCM_FREQ_LO 2
`define SCM_RANGE 2
`define SCM_FLAG 1
`define SCM_EN 0
`define SCM_HI_RC_EN_RST 1'h1
`define SCM_OTHER_EN_RST 1'h0

// Divider select and RC frequency codes
`define SCM_SEL_SUB 3'h7
`define SCM_FREQ_RSVD 2'h3
`define SCM_FREQ_8M 2'h0

// Oscillator settle time after ready, and clock period
`define SCM_SETTLE_NS 256
`define SCM_MCLK_NS 8

`endif

// ### logic/scm_pkg.sv
// Types for the system clock and operating mode controller.
// Assumes nothing beyond the tool's SystemVerilog support.
package scm_pkg;

    typedef enum logic [4:0] {
        SCM_RUN = 5'h01,
        SCM_SLEEP = 5'h02,
        SCM_IDLE_LO = 5'h04,
        SCM_IDLE_DUAL = 5'h08,
        SCM_IDLE_HI = 5'h10
    } scm_mode_t;

    typedef enum logic [2:0] {
        SCM_SW_FOLLOW = 3'h1,
        SCM_SW_DRAIN = 3'h2,
        SCM_SW_ARM = 3'h4
    } scm_sw_t;

    // Oscillator index in stability trackers
    typedef enum logic [1:0] {
        SCM_OSC_INT_HI = 2'h0,
        SCM_OSC_EXT_HI = 2'h1,
        SCM_OSC_EXT_LO = 2'h2
    } scm_osc_t;

endpackage

// ### verification/scm_top_asserts.sv
// Checker for the clock and mode controller, bound to the top module.
// Assumes one MCLK domain with synchronous active-high RST.
`timescale 1ns/1ps
`default_nettype none
module scm_top_asserts
    import scm_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Oscillator enables, CPU and clock
    input wire logic INT_HI_OSC_EN,
    input wire logic EXT_HI_OSC_EN,
    input wire logic EXT_LO_OSC_EN,
    input wire logic INT_LO_OSC_EN,
    input wire logic HALT_REQ,
    input wire logic WAKE_REQ,
    input wire logic WATCHDOG_EN,
    input wire logic CPU_RUN,
    input wire logic [4:0] MODE,
    input wire logic SYS_CLK
);
    logic [1:0] keep_q;
    wire in_run = MODE == SCM_RUN;
    wire halt = in_run && HALT_REQ;

    // Shadow of the two idle keep bits
    always_ff @(posedge MCLK) begin
        if (RST) begin
            keep_q <= 2'h0;
        end else if (PSEL && PENABLE && PWRITE && PADDR == 8'h00) begin
            keep_q <= PWDATA[1:0];
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    AST_BIT4_ZERO: assert property (PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h00
        |-> PRDATA[4] == 1'b0 && PRDATA[31:8] == 24'h0) else $error("bit 4 read nonzero");
    AST_SLEEP_ENTRY: assert property (halt && keep_q == 2'b00
        |=> MODE == SCM_SLEEP && !CPU_RUN) else $error("sleep not entered");
    AST_IDLE_LO: assert property (halt && keep_q == 2'b01 |=> MODE == SCM_IDLE_LO)
        else $error("low-only idle not entered");
    AST_IDLE_DUAL: assert property (halt && keep_q == 2'b11 |=> MODE == SCM_IDLE_DUAL)
        else $error("dual idle not entered");
    AST_IDLE_HI: assert property (halt && keep_q == 2'b10 |=> MODE == SCM_IDLE_HI)
        else $error("high-only idle not entered");
    AST_SLEEP_OFF: assert property (MODE == SCM_SLEEP
        |-> !INT_HI_OSC_EN && !EXT_HI_OSC_EN && !EXT_LO_OSC_EN) else $error("osc on in sleep");
    AST_SLEEP_WDT: assert property (MODE == SCM_SLEEP |-> INT_LO_OSC_EN == WATCHDOG_EN)
        else $error("low rc enable wrong in sleep");
    AST_WDT_KEEP: assert property (WATCHDOG_EN |-> INT_LO_OSC_EN)
        else $error("low rc off with watchdog on");
    AST_IDLE_LO_HI_OFF: assert property (MODE == SCM_IDLE_LO
        |-> !INT_HI_OSC_EN && !EXT_HI_OSC_EN) else $error("high osc on in low-only idle");
    AST_IDLE_HI_LO_OFF: assert property (MODE == SCM_IDLE_HI
        |-> !EXT_LO_OSC_EN && INT_LO_OSC_EN == WATCHDOG_EN) else $error("low osc in idle");
    AST_SLEEP_CLK: assert property ($rose(MODE == SCM_SLEEP) ##40 MODE == SCM_SLEEP
        |-> !SYS_CLK) else $error("system clock runs in sleep");
    AST_CPU_RUN: assert property (CPU_RUN == in_run)
        else $error("cpu run flag disagrees with mode");
    AST_WAKE: assert property (!in_run && WAKE_REQ |=> in_run && CPU_RUN)
        else $error("wake ignored");
endmodule

bind scm_top scm_top_asserts u_chk (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INT_HI_OSC_EN(INT_HI_OSC_EN), .EXT_HI_OSC_EN(EXT_HI_OSC_EN),
    .EXT_LO_OSC_EN(EXT_LO_OSC_EN), .INT_LO_OSC_EN(INT_LO_OSC_EN), .HALT_REQ(HALT_REQ),
    .WAKE_REQ(WAKE_REQ), .WATCHDOG_EN(WATCHDOG_EN), .CPU_RUN(CPU_RUN), .MODE(MODE),
    .SYS_CLK(SYS_CLK)
);
`default_nettype wire

// ### verification/tb_system_clock_mode_control.sv
// Self-checking bench for the clock and mode controller.
// Assumes scm_top with its checker bound; oscillators and ready pins modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_mode_control
    import scm_pkg::*;
;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err, p;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic hrc, ext_hi_crystal_osc, ext_lo_crystal_osc, lrc, hrc_rdy, hxt_rdy, lxt_rdy, lrc_rdy;
    logic hrc_en, hxt_en, lxt_en, lrc_en, hxt_rng, halt, wake, wdt, cpu_run;
    logic sys_clk, hi_clk, lo_clk, lrc_o;
    logic [1:0] freq, kp;
    logic [3:0] pv;
    logic [2:0] cd;
    logic [4:0] mode;
    int n_errors, cmp_count, n, c, ch, cl, co;

    scm_top #(.SETTLE_CYC(2)) u_dut (
        .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .INT_HI_RC_CLK(hrc), .EXT_HI_XTAL_CLK(ext_hi_crystal_osc), .EXT_LO_XTAL_CLK(ext_lo_crystal_osc),
        .INT_LO_RC_CLK(lrc), .INT_HI_READY(hrc_rdy), .EXT_HI_READY(hxt_rdy),
        .EXT_LO_READY(lxt_rdy), .INT_LO_READY(lrc_rdy), .INT_HI_OSC_EN(hrc_en),
        .EXT_HI_OSC_EN(hxt_en), .EXT_LO_OSC_EN(lxt_en), .INT_LO_OSC_EN(lrc_en),
        .INT_HI_FREQ_SEL(freq), .EXT_HI_FREQ_RANGE(hxt_rng), .HALT_REQ(halt),
        .WAKE_REQ(wake), .WATCHDOG_EN(wdt), .CPU_RUN(cpu_run), .MODE(mode),
        .SYS_CLK(sys_clk), .HI_CLK(hi_clk), .LO_CLK(lo_clk), .INT_LO_RC_CLK_O(lrc_o)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Oscillators toggle on falling MCLK edges, and stand low while disabled
    initial begin
        {hrc, ext_hi_crystal_osc, ext_lo_crystal_osc, lrc} = 4'h0;
        fork
            forever #40 hrc = hrc_en ? ~hrc : 1'b0;
            forever #24 ext_hi_crystal_osc = hxt_en ? ~ext_hi_crystal_osc : 1'b0;
            forever #152 ext_lo_crystal_osc = lxt_en ? ~ext_lo_crystal_osc : 1'b0;
            forever #200 lrc = lrc_en ? ~lrc : 1'b0;
        join
    end
    always @(posedge mclk) begin
        {hrc_rdy, hxt_rdy, lxt_rdy, lrc_rdy} <= {hrc_en, hxt_en, lxt_en, lrc_en};
    end

    task automatic stop_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic hang(input string what);
        n_errors++;
        $display("BAD %0t %s timed out", $time, what);
        stop_test();
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        {psel, penable, pwrite} <= {2'b10, w};
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) hang("apb");
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic wait_flag(input logic [7:0] a);
        int k;
        k = 0;
        do begin
            apb(a, 1'b0, 32'h0);
            k++;
        end while (rd[1] !== 1'b1 && k < 100);
        if (rd[1] !== 1'b1) hang("flag");
    endtask
    // Four SYS_CLK periods in MCLK cycles, skipping the first rise
    task automatic chk_per(input int exp, input string what);
        int k, r, k0;
        repeat (8) @(posedge mclk);
        k = 0;
        r = 0;
        k0 = 0;
        p = sys_clk;
        while (r < 6 && k < 6000) begin
            @(posedge mclk);
            k++;
            if (sys_clk === 1'b1 && p === 1'b0) r++;
            if (r == 2 && k0 == 0) k0 = k;
            p = sys_clk;
        end
        if (r < 6) hang(what);
        chk(k - k0 >= 4 * exp - 2 && k - k0 <= 4 * exp + 2, 1'b1, what);
    endtask
    function automatic logic [4:0] exp_mode(input logic [1:0] k);
        case (k)
            2'b00: return SCM_SLEEP;
            2'b01: return SCM_IDLE_LO;
            2'b11: return SCM_IDLE_DUAL;
            default: return SCM_IDLE_HI;
        endcase
    endfunction

    initial begin
        {psel, penable, pwrite, halt, wake, wdt, rst} = 7'h01;
        paddr = 8'h00;
        pwdata = 32'h0;
        {hrc_rdy, hxt_rdy, lxt_rdy, lrc_rdy} = 4'h0;
        n_errors = 0;
        cmp_count = 0;
        n = $urandom(32'hCD8A);
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0);
            chk(rd & 32'hFFFFFFFD, (i == 1) ? 32'h1 : 32'h0, "reset value");
        end
        chk_per(10, "reset clock");
        for (int i = 0; i < 6; i++) begin
            n = $urandom;
            apb(8'h00, 1'b1, 32'(n));
            apb(8'h00, 1'b0, 32'h0);
            chk(rd, {24'h0, 8'(n) & 8'hEF}, "control readback");
            apb(8'h10 + 8'(4 * ($urandom % 60)), i[0], 32'(n));
            chk(err, 1'b1, "unmapped error");
            if (!i[0]) chk(rd, 32'h0, "unmapped read");
        end
        for (int i = 0; i < 7; i++) begin
            apb(8'h00, 1'b1, {24'h0, 3'(i), 5'h0});
            chk_per(10 << i, "divided clock");
        end
        apb(8'h00, 1'b1, 32'hE0);
        chk_per(50, "low rc clock");
        apb(8'h0C, 1'b1, 32'h1);
        wait_flag(8'h0C);
        apb(8'h00, 1'b1, 32'hE4);
        chk_per(38, "low crystal clock");
        apb(8'h08, 1'b1, 32'h1);
        wait_flag(8'h08);
        chk(hxt_en, 1'b1, "slow keeps crystal");
        apb(8'h08, 1'b1, 32'h5);
        chk(hxt_rng, 1'b0, "range locked while running");
        apb(8'h00, 1'b1, 32'h08);
        chk_per(6, "crystal clock");
        apb(8'h00, 1'b1, 32'hEC);
        repeat (8) @(posedge mclk);
        apb(8'h08, 1'b1, 32'h0);
        chk(hxt_en, 1'b0, "slow stops crystal");
        apb(8'h08, 1'b1, 32'h4);
        chk(hxt_rng, 1'b1, "range write");
        apb(8'h00, 1'b1, 32'h0);
        apb(8'h0C, 1'b1, 32'h0);
        for (int i = 1; i < 5; i++) begin
            apb(8'h04, 1'b1, {28'h0, 2'(i), 2'b01});
            apb(8'h04, 1'b0, 32'h0);
            chk(rd[1], 1'b0, "rc flag clears");
            wait_flag(8'h04);
            chk(freq, (i % 4 == 3) ? 0 : i % 4, "rc frequency");
        end
        for (int i = 0; i < 16; i++) begin
            kp = (i < 4) ? 2'(i) : 2'($urandom);
            cd = ($urandom % 2 == 1) ? 3'h7 : 3'h0;
            apb(8'h00, 1'b1, {24'h0, cd, 3'h0, kp});
            wdt <= 1'($urandom);
            repeat (60) @(posedge mclk);
            halt <= 1'b1;
            @(posedge mclk);
            halt <= 1'b0;
            @(posedge mclk);
            chk(mode, exp_mode(kp), "halt mode");
            chk(cpu_run, 1'b0, "cpu stopped");
            chk(lrc_en, kp[0] | wdt, "low rc enable");
            chk(hrc_en, kp[1], "rc keep");
            repeat (60) @(posedge mclk);
            c = 0;
            ch = 0;
            cl = 0;
            co = 0;
            pv = {sys_clk, hi_clk, lo_clk, lrc_o};
            repeat (300) begin
                @(posedge mclk);
                c += int'(sys_clk & ~pv[3]);
                ch += int'(hi_clk & ~pv[2]);
                cl += int'(lo_clk & ~pv[1]);
                co += int'(lrc_o & ~pv[0]);
                pv = {sys_clk, hi_clk, lo_clk, lrc_o};
            end
            chk(c > 0, kp == 2'b11 || (kp == 2'b01 && cd == 3'h7) || (kp == 2'b10 && cd == 3'h0),
                "halted clock");
            chk(ch > 0, kp[1], "halted high clock");
            chk(cl > 0, kp[0], "halted low clock");
            chk(co > 0, kp[0] | wdt, "halted low rc clock");
            wake <= 1'b1;
            @(posedge mclk);
            wake <= 1'b0;
            @(posedge mclk);
            chk({cpu_run, mode}, {1'b1, SCM_RUN}, "wake");
        end
        stop_test();
    end
endmodule
`default_nettype wire
